// ==== uta_consts.svh ====
// offsets, field positions, reset values and levels of the serial channel
// assumes byte addresses on a 32-bit bus, one register per aligned word
`ifndef UTA_CONSTS_SVH
`define UTA_CONSTS_SVH

// register byte offsets
`define UTA_A_TXH      8'h00
`define UTA_A_RXH      8'h04
`define UTA_A_IEN      8'h08
`define UTA_A_IST      8'h0C
`define UTA_A_FCTL     8'h10
`define UTA_A_LCTL     8'h14
`define UTA_A_MCTL     8'h18
`define UTA_A_LSTAT    8'h1C
`define UTA_A_EFEAT    8'h20
`define UTA_A_DIV      8'h24
`define UTA_A_DFRAC    8'h28

// field positions
`define UTA_FC_EN      0
`define UTA_FC_RXRST   1
`define UTA_FC_TXRST   2
`define UTA_IE_RX      0
`define UTA_IE_TX      1
`define UTA_IE_RTS     6
`define UTA_IE_CTS     7
`define UTA_EF_ENH     4
`define UTA_EF_ARTS    6
`define UTA_EF_ACTS    7
`define UTA_MC_RTS     1
`define UTA_LC_STOP2   2
`define UTA_LC_PAREN   3
`define UTA_LC_EVEN    4

// reset values
`define UTA_RST_REG    8'h00
`define UTA_RST_DIV    16'h0001

// int_status codes
`define UTA_IS_NONE    8'h01
`define UTA_IS_TMO     8'h0C
`define UTA_IS_RXRDY   8'h04
`define UTA_IS_TXE     8'h02
`define UTA_IS_FLOW    8'h20

// sampling modes and samples per bit minus one
`define UTA_MODE_16X   2'h0
`define UTA_MODE_8X    2'h1
`define UTA_MODE_4X    2'h2
`define UTA_SPB_16X    4'hF
`define UTA_SPB_8X     4'h7
`define UTA_SPB_4X     4'h3

// fifo depth and trigger / hysteresis levels
`define UTA_DEPTH      6'h20
`define UTA_LVL_8      6'h08
`define UTA_LVL_16     6'h10
`define UTA_LVL_24     6'h18
`define UTA_LVL_28     6'h1C
`define UTA_LVL_0      6'h00
`define UTA_TMO_BASE   6'h14  // four words of five bits
`define UTA_TMO_EXTRA  6'h0C

`endif

// ==== uta_pkg.sv ====
// types shared by the serial channel core and its fifo storage
// assumes the constants header is compiled alongside
package uta_pkg;

   // serial frame position, shared by transmitter and receiver
   typedef enum logic [2:0] {
      UTA_IDLE  = 3'b000,
      UTA_START = 3'b001,
      UTA_DATA  = 3'b010,
      UTA_PAR   = 3'b011,
      UTA_STOP  = 3'b100
   } uta_ser_t;

   // one receive fifo entry: three error tags and the data byte
   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } uta_rx_ent_t;

   typedef struct packed {
      uta_ser_t   st;
      logic [3:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic       par;
      logic       stopn;
      logic       txd;
   } uta_tx_t;

   typedef struct packed {
      uta_ser_t   st;
      logic [3:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic       pe;
      logic       prev;
   } uta_rx_t;

   // whole state of the core
   typedef struct packed {
      logic        dp_act;
      logic        dp_wr;
      logic [7:0]  dp_addr;
      logic [31:0] rdata;
      logic [7:0]  int_enable;
      logic [7:0]  fifo_control;
      logic [7:0]  line_control;
      logic [7:0]  modem_control;
      logic [7:0]  enhanced_feature;
      logic [15:0] div;
      logic [7:0]  dfrac;
      logic [15:0] bcnt;
      logic        tick;
      logic [3:0]  btcnt;
      uta_tx_t     tx;
      uta_rx_t     rx;
      logic [5:0]  txwp;
      logic [5:0]  txrp;
      logic [5:0]  rxwp;
      logic [5:0]  rxrp;
      logic        ovr;
      logic [5:0]  tmo;
      logic        tmo_flag;
      logic        txe_int;
      logic        txe_prev;
      logic        fc_int;
      logic        rts_off;
      logic        rts_n;
      logic        cts_prev;
      logic        irq;
   } uta_state_t;

endpackage

// ==== uta_mem.sv ====
// 32-entry storage for one fifo, registered read data
// assumes write and read addresses come from the owning fifo pointers
`timescale 1ns/100ps
`default_nettype none
module uta_mem #(
   parameter int W = 8
) (
   // clock
   input  wire logic         clk,
   // write side
   input  wire logic         we,
   input  wire logic [4:0]   waddr,
   input  wire logic [W-1:0] wdata,
   // read side
   input  wire logic [4:0]   raddr,
   output logic      [W-1:0] rdata
);

   logic [W-1:0] mem [0:31];

   // write, and read with bypass so a fresh head is seen at once
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (we && (waddr == raddr)) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end

endmodule
`default_nettype wire

// ==== uta_core.sv ====
// one serial channel: transmitter, receiver, fifos, auto rts/cts
// assumes a single AHB-Lite master; rxd and cts_n synchronous to hclk
`timescale 1ns/100ps
`default_nettype none
`include "uta_consts.svh"

module uta_core
   import uta_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // serial link
   input  wire logic        rxd,
   output logic             txd,
   input  wire logic        cts_n,
   output logic             rts_n,
   // interrupt
   output logic             irq
);

   uta_state_t  s_q;
   uta_state_t  s_d;
   logic [5:0]  tx_cnt;
   logic [5:0]  rx_cnt;
   logic [5:0]  cap;
   logic [5:0]  rx_trig;
   logic [5:0]  rx_hi;
   logic [5:0]  rx_lo;
   logic [5:0]  tx_trig;
   logic [5:0]  tmo_lim;
   logic [3:0]  spb_m1;
   logic [3:0]  half_m1;
   logic [2:0]  wl_last;
   logic [7:0]  dmask;
   logic        rx_rdy;
   logic        txe_cond;
   logic [7:0]  isr_code;
   logic [7:0]  line_status;
   logic        ap;
   logic        tx_push;
   logic        tx_pop;
   logic        rx_push;
   logic        rx_pop;
   logic        rts_auto;
   logic [7:0]  tx_head;
   uta_rx_ent_t rx_head;
   uta_rx_ent_t rx_ent;
   logic [7:0]  wd;

   // the slave never stretches a transfer and always answers okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;
   assign txd       = s_q.tx.txd;
   assign rts_n     = s_q.rts_n;
   assign irq       = s_q.irq;
   assign wd        = hwdata[7:0];

   // fill levels; non-fifo mode behaves as a one-deep fifo
   assign tx_cnt = s_q.txwp - s_q.txrp;
   assign rx_cnt = s_q.rxwp - s_q.rxrp;
   assign cap    = s_q.fifo_control[`UTA_FC_EN] ? `UTA_DEPTH : 6'h01;
   assign ap     = hsel & htrans[1] & hready;
   assign rts_auto = s_q.enhanced_feature[`UTA_EF_ARTS] & s_q.modem_control[`UTA_MC_RTS];
   assign wl_last  = 3'h4 + {1'b0, s_q.line_control[1:0]};
   assign tmo_lim  = `UTA_TMO_BASE + {2'h0, s_q.line_control[1:0], 2'h0}
                     + `UTA_TMO_EXTRA;

   // level tables, bit timing and data mask
   always_comb begin
      unique case (s_q.fifo_control[7:6])
         2'h0: begin
            rx_trig = `UTA_LVL_8;
            rx_hi   = `UTA_LVL_16;
            rx_lo   = `UTA_LVL_0;
         end
         2'h1: begin
            rx_trig = `UTA_LVL_16;
            rx_hi   = `UTA_LVL_24;
            rx_lo   = `UTA_LVL_8;
         end
         2'h2: begin
            rx_trig = `UTA_LVL_24;
            rx_hi   = `UTA_LVL_28;
            rx_lo   = `UTA_LVL_16;
         end
         2'h3: begin
            rx_trig = `UTA_LVL_28;
            rx_hi   = `UTA_LVL_28;
            rx_lo   = `UTA_LVL_24;
         end
      endcase
      unique case (s_q.fifo_control[5:4])
         2'h0: tx_trig = `UTA_LVL_8;
         2'h1: tx_trig = `UTA_LVL_16;
         2'h2: tx_trig = `UTA_LVL_24;
         2'h3: tx_trig = `UTA_LVL_28;
      endcase
      unique case (s_q.dfrac[5:4])
         `UTA_MODE_8X: spb_m1 = `UTA_SPB_8X;
         `UTA_MODE_4X: spb_m1 = `UTA_SPB_4X;
         default:      spb_m1 = `UTA_SPB_16X;
      endcase
      half_m1 = spb_m1 >> 1;
      dmask   = 8'hFF >> (2'h3 - s_q.line_control[1:0]);
   end

   // interrupt sources and line status
   always_comb begin
      rx_rdy   = s_q.fifo_control[`UTA_FC_EN] ? (rx_cnt >= rx_trig)
                                     : (rx_cnt != 6'h00);
      txe_cond = s_q.fifo_control[`UTA_FC_EN] ? (tx_cnt < tx_trig)
                                     : (tx_cnt == 6'h00);
      if (s_q.int_enable[`UTA_IE_RX] && s_q.tmo_flag) begin
         isr_code = `UTA_IS_TMO;
      end else if (s_q.int_enable[`UTA_IE_RX] && rx_rdy) begin
         isr_code = `UTA_IS_RXRDY;
      end else if (s_q.int_enable[`UTA_IE_TX] && s_q.txe_int) begin
         isr_code = `UTA_IS_TXE;
      end else if (s_q.fc_int) begin
         isr_code = `UTA_IS_FLOW;
      end else begin
         isr_code = `UTA_IS_NONE;
      end
      line_status = 8'h00;
      line_status[0] = (rx_cnt != 6'h00);
      line_status[1] = s_q.ovr;
      if (rx_cnt != 6'h00) begin
         line_status[4:2] = {rx_head.brk, rx_head.fe, rx_head.pe};
      end
      line_status[5] = (tx_cnt == 6'h00);
      line_status[6] = (tx_cnt == 6'h00) && (s_q.tx.st == UTA_IDLE);
   end

   // next state of the whole channel
   always_comb begin
      s_d     = s_q;
      tx_push = 1'b0;
      tx_pop  = 1'b0;
      rx_push = 1'b0;
      rx_pop  = 1'b0;
      rx_ent  = '0;

      // oversampling tick from the integer divisor
      s_d.tick = 1'b0;
      if (s_q.bcnt + 16'h0001 >= s_q.div) begin
         s_d.bcnt = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.bcnt = s_q.bcnt + 16'h0001;
      end

      // address phase: reads answered and their side effects taken
      s_d.dp_act  = ap;
      s_d.dp_wr   = hwrite;
      s_d.dp_addr = haddr[7:0];
      if (ap && !hwrite) begin
         s_d.rdata = 32'h0000_0000;
         unique case (haddr[7:0])
            `UTA_A_RXH: begin
               s_d.rdata[7:0] = rx_head.data;
               rx_pop = (rx_cnt != 6'h00);
            end
            `UTA_A_IEN:   s_d.rdata[7:0] = s_q.int_enable;
            `UTA_A_IST: begin
               s_d.rdata[7:0] = isr_code;
               if (isr_code == `UTA_IS_TXE) s_d.txe_int = 1'b0;
               if (isr_code == `UTA_IS_FLOW) s_d.fc_int = 1'b0;
            end
            `UTA_A_FCTL:  s_d.rdata[7:0] = s_q.fifo_control;
            `UTA_A_LCTL:  s_d.rdata[7:0] = s_q.line_control;
            `UTA_A_MCTL:  s_d.rdata[7:0] = s_q.modem_control;
            `UTA_A_LSTAT: begin
               s_d.rdata[7:0] = line_status;
               s_d.ovr = 1'b0;
            end
            `UTA_A_EFEAT: s_d.rdata[7:0] = s_q.enhanced_feature;
            `UTA_A_DIV:   s_d.rdata[15:0] = s_q.div;
            `UTA_A_DFRAC: s_d.rdata[7:0] = s_q.dfrac;
            default:      s_d.rdata = 32'h0000_0000;
         endcase
      end

      // data phase: writes land with hwdata
      if (s_q.dp_act && s_q.dp_wr) begin
         unique case (s_q.dp_addr)
            `UTA_A_TXH: begin
               tx_push = (tx_cnt < cap);
               s_d.txe_int = 1'b0;
            end
            `UTA_A_IEN: begin
               s_d.int_enable[3:0] = wd[3:0];
               if (s_q.enhanced_feature[`UTA_EF_ENH]) s_d.int_enable[7:4] = wd[7:4];
            end
            `UTA_A_FCTL: begin
               s_d.fifo_control = {wd[7:3], 2'h0, wd[0]};
               if (wd[`UTA_FC_RXRST] || (wd[0] != s_q.fifo_control[0])) begin
                  s_d.rxrp = s_q.rxwp;
               end
               if (wd[`UTA_FC_TXRST] || (wd[0] != s_q.fifo_control[0])) begin
                  s_d.txrp = s_q.txwp;
               end
            end
            `UTA_A_LCTL:  s_d.line_control = wd;
            `UTA_A_MCTL:  s_d.modem_control = wd;
            `UTA_A_EFEAT: s_d.enhanced_feature = wd;
            `UTA_A_DIV:   s_d.div = hwdata[15:0];
            `UTA_A_DFRAC: s_d.dfrac = wd;
            default: begin
            end
         endcase
      end

      // free bit clock for the time-out
      if (s_q.tick) begin
         s_d.btcnt = (s_q.btcnt == spb_m1) ? 4'h0 : s_q.btcnt + 4'h1;
      end

      // transmitter
      unique case (s_q.tx.st)
         UTA_IDLE: begin
            s_d.tx.txd = 1'b1;
            if (s_q.tick && (tx_cnt != 6'h00) &&
                !(s_q.enhanced_feature[`UTA_EF_ACTS] && cts_n)) begin
               s_d.tx.sh  = tx_head & dmask;
               s_d.tx.par = (^(tx_head & dmask)) ^ ~s_q.line_control[`UTA_LC_EVEN];
               s_d.tx.st  = UTA_START;
               s_d.tx.cnt = 4'h0;
               s_d.tx.txd = 1'b0;
               tx_pop     = 1'b1;
            end
         end
         default: begin
            if (s_q.tick) begin
               if (s_q.tx.cnt == spb_m1) begin
                  s_d.tx.cnt = 4'h0;
                  unique case (s_q.tx.st)
                     UTA_START: begin
                        s_d.tx.st   = UTA_DATA;
                        s_d.tx.bitn = 3'h0;
                        s_d.tx.txd  = s_q.tx.sh[0];
                     end
                     UTA_DATA: begin
                        if (s_q.tx.bitn == wl_last) begin
                           s_d.tx.stopn = s_q.line_control[`UTA_LC_STOP2];
                           if (s_q.line_control[`UTA_LC_PAREN]) begin
                              s_d.tx.st  = UTA_PAR;
                              s_d.tx.txd = s_q.tx.par;
                           end else begin
                              s_d.tx.st  = UTA_STOP;
                              s_d.tx.txd = 1'b1;
                           end
                        end else begin
                           s_d.tx.bitn = s_q.tx.bitn + 3'h1;
                           s_d.tx.txd  = s_q.tx.sh[s_q.tx.bitn + 3'h1];
                        end
                     end
                     UTA_PAR: begin
                        s_d.tx.st  = UTA_STOP;
                        s_d.tx.txd = 1'b1;
                     end
                     default: begin
                        if (s_q.tx.stopn) begin
                           s_d.tx.stopn = 1'b0;
                        end else begin
                           s_d.tx.st = UTA_IDLE;
                        end
                     end
                  endcase
               end else begin
                  s_d.tx.cnt = s_q.tx.cnt + 4'h1;
                  // last stop tick is spent in idle so frames abut
                  if ((s_q.tx.st == UTA_STOP) && !s_q.tx.stopn &&
                      (s_d.tx.cnt == spb_m1)) begin
                     s_d.tx.st = UTA_IDLE;
                  end
               end
            end
         end
      endcase

      // receiver
      s_d.rx.prev = rxd;
      unique case (s_q.rx.st)
         UTA_IDLE: begin
            if (s_q.rx.prev && !rxd) begin
               s_d.rx.st  = UTA_START;
               s_d.rx.cnt = 4'h0;
               s_d.rx.sh  = 8'h00;
               s_d.rx.pe  = 1'b0;
            end
         end
         UTA_START: begin
            if (s_q.tick) begin
               if (s_q.rx.cnt == half_m1) begin
                  s_d.rx.cnt  = 4'h0;
                  s_d.rx.bitn = 3'h0;
                  s_d.rx.st   = rxd ? UTA_IDLE : UTA_DATA;
               end else begin
                  s_d.rx.cnt = s_q.rx.cnt + 4'h1;
               end
            end
         end
         UTA_DATA, UTA_PAR, UTA_STOP: begin
            if (s_q.tick) begin
               if (s_q.rx.cnt == spb_m1) begin
                  s_d.rx.cnt = 4'h0;
                  if (s_q.rx.st == UTA_DATA) begin
                     s_d.rx.sh[s_q.rx.bitn] = rxd;
                     if (s_q.rx.bitn == wl_last) begin
                        s_d.rx.st = s_q.line_control[`UTA_LC_PAREN] ? UTA_PAR
                                                           : UTA_STOP;
                     end else begin
                        s_d.rx.bitn = s_q.rx.bitn + 3'h1;
                     end
                  end else if (s_q.rx.st == UTA_PAR) begin
                     s_d.rx.pe = rxd ^ (^s_q.rx.sh)
                                 ^ ~s_q.line_control[`UTA_LC_EVEN];
                     s_d.rx.st = UTA_STOP;
                  end else begin
                     rx_ent.data = s_q.rx.sh;
                     rx_ent.pe   = s_q.rx.pe;
                     rx_ent.fe   = !rxd;
                     rx_ent.brk  = !rxd && (s_q.rx.sh == 8'h00);
                     s_d.rx.st   = UTA_IDLE;
                     if ((rx_cnt - {5'h00, rx_pop}) < cap) begin
                        rx_push = 1'b1;
                     end else begin
                        s_d.ovr = 1'b1;
                     end
                  end
               end else begin
                  s_d.rx.cnt = s_q.rx.cnt + 4'h1;
               end
            end
         end
         default: s_d.rx.st = UTA_IDLE;
      endcase

      // fifo pointers
      if (tx_push) s_d.txwp = s_q.txwp + 6'h01;
      if (tx_pop)  s_d.txrp = s_q.txrp + 6'h01;
      if (rx_push) s_d.rxwp = s_q.rxwp + 6'h01;
      if (rx_pop)  s_d.rxrp = s_q.rxrp + 6'h01;

      // receive time-out counts bit times while data waits unread
      if ((rx_cnt == 6'h00) || rx_push || rx_pop) begin
         s_d.tmo      = 6'h00;
         s_d.tmo_flag = 1'b0;
      end else if (s_q.tick && (s_q.btcnt == spb_m1)) begin
         if (s_q.tmo + 6'h01 >= tmo_lim) begin
            s_d.tmo_flag = 1'b1;
         end else begin
            s_d.tmo = s_q.tmo + 6'h01;
         end
      end

      // transmit-empty event, set wins over any clear above
      s_d.txe_prev = txe_cond;
      if (txe_cond && !s_q.txe_prev) s_d.txe_int = 1'b1;

      // auto rts with hysteresis
      if (!rts_auto) begin
         s_d.rts_off = 1'b0;
      end else if (rx_cnt >= rx_hi) begin
         s_d.rts_off = 1'b1;
      end else if (rx_cnt <= rx_lo) begin
         s_d.rts_off = 1'b0;
      end
      s_d.rts_n = !(s_q.modem_control[`UTA_MC_RTS] &&
                    !(s_q.enhanced_feature[`UTA_EF_ARTS] && s_q.rts_off));

      // flow-control interrupt on rts_n or cts_n rising
      s_d.cts_prev = cts_n;
      if (s_q.int_enable[`UTA_IE_RTS] && s_d.rts_n && !s_q.rts_n) begin
         s_d.fc_int = 1'b1;
      end
      if (s_q.int_enable[`UTA_IE_CTS] && cts_n && !s_q.cts_prev) begin
         s_d.fc_int = 1'b1;
      end
      s_d.irq = (isr_code != `UTA_IS_NONE);
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q          <= '0;
         s_q.div      <= `UTA_RST_DIV;
         s_q.tx.txd   <= 1'b1;
         s_q.rx.prev  <= 1'b1;
         s_q.rts_n    <= 1'b1;
         s_q.cts_prev <= 1'b1;
         s_q.txe_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // transmit fifo storage
   uta_mem #(.W(8)) u_txmem (
      .clk   (hclk),
      .we    (tx_push),
      .waddr (s_q.txwp[4:0]),
      .wdata (wd),
      .raddr (s_d.txrp[4:0]),
      .rdata (tx_head)
   );

   // receive fifo storage, data plus error tags
   uta_mem #(.W(11)) u_rxmem (
      .clk   (hclk),
      .we    (rx_push),
      .waddr (s_q.rxwp[4:0]),
      .wdata (rx_ent),
      .raddr (s_d.rxrp[4:0]),
      .rdata (rx_head)
   );

endmodule
`default_nettype wire

// ==== uta_core_checker.sv ====
// concurrent checks on the ports of the serial channel core
// assumes divisor 1 and auto cts on whenever cts_n is held high
`timescale 1ns/100ps
`default_nettype none
module uta_core_checker (
   // clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // serial link and interrupt
   input wire logic        txd,
   input wire logic        cts_n,
   input wire logic        rts_n,
   input wire logic        irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [8:0] cts_q;
   // cycles with cts_n high, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cts_q <= 9'h000;
      else if (cts_n == 1'b0) cts_q <= 9'h000;
      else if (cts_q != 9'h1FF) cts_q <= cts_q + 9'h001;
   end
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus wait or error");
   property p_idle; $rose(hresetn) |-> txd; endproperty
   a_idle: assert property (p_idle) else $error("txd low at reset");
   property p_rts0; $rose(hresetn) |-> rts_n; endproperty
   a_rts0: assert property (p_rts0) else $error("rts on at reset");
   property p_irq0; $rose(hresetn) |-> !irq; endproperty
   a_irq0: assert property (p_irq0) else $error("irq at reset");
   property p_low; $fell(txd) |-> !txd [*4]; endproperty
   a_low: assert property (p_low) else $error("short low bit");
   property p_high; $rose(txd) |-> txd [*4]; endproperty
   a_high: assert property (p_high) else $error("short high bit");
   property p_hold;
      !(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_cts; cts_q > 9'd200 |-> !$fell(txd); endproperty
   a_cts: assert property (p_cts) else $error("start while cts off");
   c_rts: cover property ($rose(rts_n));
   c_irq: cover property ($rose(irq));
   c_cts: cover property (cts_q == 9'd200);
endmodule
bind uta_core uta_core_checker i_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txd(txd),
   .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
`default_nettype wire

// ==== uta_remote.sv ====
// remote serial partner: decodes txd frames, sends frames on rxd
// assumes bitlen gives hclk cycles per bit, 8 data bits, no parity
`timescale 1ns/100ps
`default_nettype none
module uta_remote (
   // clock and bit length
   input  wire logic       hclk,
   input  wire logic [4:0] bitlen,
   // serial link
   input  wire logic       txd,
   output logic            rxd
);
   logic [7:0] got_q [$];
   // sample each frame at bit centres
   initial begin
      logic [7:0] b;
      rxd = 1'b1;
      forever begin
         @(negedge txd);
         repeat (bitlen / 2) @(posedge hclk);
         for (int i = 0; i < 8; i++) begin
            repeat (bitlen) @(posedge hclk);
            b[i] = txd;
         end
         repeat (bitlen) @(posedge hclk);
         if (txd === 1'b1) got_q.push_back(b);
      end
   end
   // one frame, lsb first, two stop bits
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {2'b11, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (bitlen) @(posedge hclk);
      end
   endtask
endmodule
`default_nettype wire

// ==== uta_core_tb_top.sv ====
// top testbench of the serial channel core
// assumes checker and remote partner are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "uta_consts.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
   error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module uta_core_tb_top;
   logic        hclk, hresetn, hsel, hwrite, txd, rxd, cts_n, rts_n, irq;
   logic        hreadyout, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [4:0]  bitlen;
   int          error_cnt, n_compared;
   uta_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
      .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
   uta_remote i_rem (.hclk(hclk), .bitlen(bitlen), .txd(txd), .rxd(rxd));
   // verdict and end of run
   task automatic complete_run;
      $display("error_cnt %0d n_compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // bounded wait for hready
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin error_cnt++; complete_run(); end
   endtask
   // one AHB single transfer
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      rd = hrdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      `CHK("read", e, rd[7:0])
   endtask
   // bounded wait for frames at the partner
   task automatic wait_rx(input int k);
      int n;
      n = 0;
      while (i_rem.got_q.size() < k && n < 5000) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 5000) begin error_cnt++; complete_run(); end
   endtask
   // 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // main sequence
   initial begin
      {hresetn, hsel, hwrite, cts_n} = 4'h0;
      {htrans, haddr, hwdata} = '0;
      {bitlen, error_cnt, n_compared} = {5'h10, 32'h0, 32'h0};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(`UTA_A_LSTAT, 8'h60);
      rdc(8'h3C, 8'h00);
      bus(1'b1, `UTA_A_FCTL, 32'h1);
      bus(1'b1, `UTA_A_LCTL, 32'h3);
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, `UTA_A_DFRAC, 32'(m << 4));
         bitlen <= 5'h10 >> m;
         bus(1'b1, `UTA_A_TXH, 32'(8'hA5 + m));
         bus(1'b1, `UTA_A_TXH, 32'(8'h3C ^ m));
         rdc(`UTA_A_LSTAT, 8'h00);
         i_rem.send(8'(8'h5A ^ m));
         rdc(`UTA_A_RXH, 8'(8'h5A ^ m));
         wait_rx(2 * m + 2);
         `CHK("tx0", 8'(8'hA5 + m), i_rem.got_q[2*m])
         `CHK("tx1", 8'(8'h3C ^ m), i_rem.got_q[2*m+1])
         repeat (16) @(posedge hclk);
         rdc(`UTA_A_LSTAT, 8'h60);
      end
      bus(1'b1, `UTA_A_EFEAT, 32'h50);
      bus(1'b1, `UTA_A_IEN, 32'h40);
      bus(1'b1, `UTA_A_MCTL, 32'h02);
      repeat (2) @(posedge hclk);
      `CHK("rts on", 1'b0, rts_n)
      for (int i = 0; i < 17; i++) begin
         i_rem.send(8'(i));
         `CHK("rts fill", 1'(i >= 15), rts_n)
      end
      `CHK("irq", 1'b1, irq)
      rdc(`UTA_A_IST, 8'h20);
      for (int i = 0; i < 17; i++) begin
         rdc(`UTA_A_RXH, 8'(i));
         repeat (2) @(posedge hclk);
         `CHK("rts drain", 1'(i < 16), rts_n)
      end
      bus(1'b1, `UTA_A_EFEAT, 32'hD0);
      bus(1'b1, `UTA_A_IEN, 32'h80);
      cts_n <= 1'b1;
      repeat (3) @(posedge hclk);
      rdc(`UTA_A_IST, 8'h20);
      bus(1'b1, `UTA_A_TXH, 32'h96);
      repeat (300) @(posedge hclk);
      `CHK("held", 6, i_rem.got_q.size())
      cts_n <= 1'b0;
      wait_rx(7);
      `CHK("resumed", 8'h96, i_rem.got_q[6])
      bus(1'b1, `UTA_A_IEN, 32'h01);
      i_rem.send(8'h71);
      rdc(`UTA_A_IST, 8'h01);
      repeat (200) @(posedge hclk);
      `CHK("irq tmo", 1'b1, irq)
      rdc(`UTA_A_IST, 8'h0C);
      rdc(`UTA_A_RXH, 8'h71);
      for (int i = 0; i < 8; i++) i_rem.send(8'(i));
      rdc(`UTA_A_IST, 8'h04);
      bus(1'b1, `UTA_A_FCTL, 32'h0);
      bus(1'b1, `UTA_A_IEN, 32'h02);
      bus(1'b1, `UTA_A_TXH, 32'h2D);
      repeat (2) @(posedge hclk);
      rdc(`UTA_A_LSTAT, 8'h20);
      rdc(`UTA_A_IST, 8'h02);
      rdc(`UTA_A_IST, 8'h01);
      wait_rx(8);
      `CHK("nonfifo", 8'h2D, i_rem.got_q[7])
      complete_run();
   end
endmodule
`default_nettype wire
